// file: src/pmmg_guard.sv
// Purpose: Privilege mode control, fuse row guard, MMU and register access gate
// Assumes: One 25 MHz clock; CPU access inputs synchronous and held one cycle
// Notes:   Memory answers are registered one cycle after the request
//
// Behaviour
// - Every reset starts in boot mode; test if available and not delivered, else system mode.
// - Boot may go to test or contactless mode; never back to boot.
// - After delivery test mode entry is blocked until the next reset.
// - Boot mode lives only in the boot phase after reset.
// - After test phase, super-system flag only selects contactless mode.
// - Top 128 bytes of the lower EEPROM half form the guarded fuse row; its unused bytes are hidden.
// - A 32-byte fuse area is readable, never writable, by application.
// - A 16-byte fuse area can be write protected by software on demand.
// - A 32-byte write-once fuse area keeps every set bit at one.
// - Factory key area sits outside the fuse row with no protection.
// - CPU gives virtual addresses; MMU outputs physical addresses.
// - EEPROM and ROM split in fixed halves; only test mode sees both.
// - User mode segments EEPROM, ROM part and RAM with R/W/X rights.
// - Segments configured in system mode, enforced only in user mode.
// - Each segment entry holds rights, start, end, offset, register rights.
// - Physical address adds offset and is checked against the partition.
// - Up to 64 segments; an end marker allows fewer segments.
// - Segment register rights cover 16 groups and feed the register gate.
// - Privileged modes report full access to all register groups.
// - Segment breaches and out-of-range addresses raise an exception.
// - Refused register writes change nothing; refused reads return a constant.
// - Non-group registers follow fixed wired rules independent of MMU.
// - Status word holds super-system and system flags; both zero means user.
// - Software writes to the two flags can only clear them.
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "pmmg_map.svh"

module pmmg_guard
  import pmmg_pkg::*;
#(
  parameter int SEGS   = 64,
  parameter int GROUPS = 16
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Mode straps and CPU mode events
  input  wire logic        test_avail,
  input  wire logic        svec_call,
  input  wire logic        user_call,
  input  wire logic        cless_req,
  input  wire logic        test_req,
  // CPU memory access
  input  wire logic        mem_req,
  input  wire logic [1:0]  mem_kind,
  input  wire logic [23:0] mem_vaddr,
  // Memory side
  output logic             mem_en,
  output logic             mem_we,
  output logic [23:0]      mem_paddr,
  output logic             mem_exc,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // Mode status
  output logic [2:0]       cpu_mode
);

  // --------------------------------------------------------------------------
  // Mode state
  // --------------------------------------------------------------------------
  pmmg_mode_e mode;
  logic       ssm_flag;
  logic       sm_flag;
  logic       delivered;
  logic       test_left;
  logic       wp_lock;
  pmmg_mode_e next_mode;

  // Segment table storage
  logic [3:0]         seg_rights [SEGS];
  logic [23:0]        seg_start  [SEGS];
  logic [23:0]        seg_end    [SEGS];
  logic [23:0]        seg_offs   [SEGS];
  logic [GROUPS-1:0]  seg_periph [SEGS];
  logic [5:0]         seg_sel;
  logic [31:0]        sfr_bank   [GROUPS];
  logic [23:0]        fault_addr;

  // Decoded user-mode and privileged status
  wire is_user  = !ssm_flag && !sm_flag;
  wire is_priv  = !is_user;
  wire wr_psw   = reg_wr && reg_addr == `PMMG_REG_PSW;
  wire wr_ctrl  = reg_wr && reg_addr == `PMMG_REG_CTRL;
  wire sys_cfg  = mode == PMMG_SYSTEM || mode == PMMG_BOOT || mode == PMMG_TEST;

  // Mode transitions; boot is never a target once left
  always_comb begin
    next_mode = mode;
    unique case (mode)
      PMMG_BOOT: begin
        if (test_req && test_avail && !delivered)
          next_mode = PMMG_TEST;
        else if (cless_req)
          next_mode = PMMG_CLESS;
        else if (wr_ctrl && reg_wdata[`PMMG_CTRL_BOOTDONE])
          next_mode = (test_avail && !delivered) ? PMMG_TEST : PMMG_SYSTEM;
      end
      PMMG_TEST: begin
        if (cless_req)
          next_mode = PMMG_CLESS;
        else if (!ssm_flag)
          next_mode = sm_flag ? PMMG_SYSTEM : PMMG_USER;
      end
      PMMG_CLESS: begin
        if (!ssm_flag)
          next_mode = sm_flag ? PMMG_SYSTEM : PMMG_USER;
      end
      PMMG_SYSTEM: begin
        if (user_call || !sm_flag)
          next_mode = PMMG_USER;
      end
      PMMG_USER: begin
        if (svec_call || mem_exc)
          next_mode = PMMG_SYSTEM;
        else if (cless_req && ssm_flag)
          next_mode = PMMG_CLESS;
      end
      default: next_mode = PMMG_SYSTEM;
    endcase
  end

  // Mode register and flags; reset always re-enters boot
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode      <= PMMG_BOOT;
      ssm_flag  <= 1'b1;
      sm_flag   <= 1'b0;
      test_left <= 1'b0;
    end else begin
      mode <= next_mode;
      if (next_mode == PMMG_SYSTEM)
        ssm_flag <= 1'b0;
      else if (next_mode == PMMG_USER)
        ssm_flag <= 1'b0;
      else if (wr_psw && !reg_wdata[`PMMG_PSW_SSM_BIT])
        ssm_flag <= 1'b0;
      // Set only on entry, so a software clear while in system mode can land
      if (next_mode == PMMG_SYSTEM && mode != PMMG_SYSTEM)
        sm_flag <= 1'b1;
      else if (next_mode == PMMG_USER || (wr_psw && !reg_wdata[`PMMG_PSW_SM_BIT]))
        sm_flag <= 1'b0;
      if (mode == PMMG_TEST && next_mode != PMMG_TEST)
        test_left <= 1'b1;
    end
  end

  // Delivery fuse and write-protect lock are one-way sticky bits
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      delivered <= 1'b0;
      wp_lock   <= 1'b0;
    end else begin
      if (wr_ctrl && reg_wdata[`PMMG_CTRL_DELIVER] && is_priv)
        delivered <= 1'b1;
      if (wr_ctrl && reg_wdata[`PMMG_CTRL_WP_BIT])
        wp_lock <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Segment lookup: first matching entry before an end marker wins
  // --------------------------------------------------------------------------
  logic              hit;
  logic [3:0]        hit_rights;
  logic [23:0]       hit_offs;
  logic [GROUPS-1:0] hit_periph;
  always_comb begin
    logic stop;
    stop       = 1'b0;
    hit        = 1'b0;
    hit_rights = 4'h0;
    hit_offs   = 24'h00_0000;
    hit_periph = '0;
    for (int i = 0; i < SEGS; i++) begin
      if (seg_rights[i][`PMMG_RIGHT_END])
        stop = 1'b1;
      if (!stop && !hit && mem_vaddr >= seg_start[i] && mem_vaddr <= seg_end[i]) begin
        hit        = 1'b1;
        hit_rights = seg_rights[i];
        hit_offs   = seg_offs[i];
        hit_periph = seg_periph[i];
      end
    end
  end

  // Translation and fixed partition check
  wire [23:0] paddr    = is_user ? 24'(mem_vaddr + hit_offs) : mem_vaddr;
  wire        full     = mode == PMMG_TEST;
  wire [23:0] ee_lim   = full ? `PMMG_EE_SIZE : `PMMG_EE_SPLIT;
  wire [23:0] rom_lim  = full ? `PMMG_ROM_SIZE : `PMMG_ROM_SPLIT;
  wire        in_ee    = paddr >= `PMMG_EE_BASE && paddr < 24'(`PMMG_EE_BASE + ee_lim);
  wire        in_rom   = paddr < 24'(`PMMG_ROM_BASE + rom_lim);
  wire        in_ram   = paddr >= `PMMG_RAM_BASE && paddr < 24'(`PMMG_RAM_BASE + `PMMG_RAM_SIZE);
  // Fuse row: top of the system half so the application space ends below it
  wire [23:0] fuse_base = 24'(`PMMG_EE_BASE + `PMMG_EE_SPLIT - `PMMG_FUSE_BYTES);
  wire [23:0] fuse_off  = 24'(paddr - fuse_base);
  wire        in_fuse   = in_ee && paddr >= fuse_base && fuse_off < `PMMG_FUSE_BYTES;
  wire        f_ro      = in_fuse && fuse_off < `PMMG_RO_BYTES;
  wire        f_wp      = in_fuse && fuse_off >= `PMMG_RO_BYTES
                          && fuse_off < 24'(`PMMG_RO_BYTES + `PMMG_WP_BYTES);
  wire        f_wo      = in_fuse && fuse_off >= 24'(`PMMG_RO_BYTES + `PMMG_WP_BYTES)
                          && fuse_off < 24'(`PMMG_RO_BYTES + `PMMG_WP_BYTES + `PMMG_WO_BYTES);
  wire        f_hidden  = in_fuse && !f_ro && !f_wp && !f_wo;
  wire        is_wr     = mem_kind == PMMG_ACC_WRITE;
  // Write-once bytes are only written as an OR mask by the EEPROM, so clears never land
  wire        fuse_bad  = !full && ((is_wr && (f_ro || (f_wp && wp_lock)))
                          || f_hidden);
  wire        range_bad = !(in_ee || in_rom || in_ram);
  wire        seg_need  = mode == PMMG_USER;
  wire [1:0]  kind_bit  = mem_kind;
  wire        seg_bad   = seg_need && (!hit || !hit_rights[kind_bit]);
  wire        violation = mem_req && (range_bad || fuse_bad || seg_bad);

  // Memory port and exception are registered
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_en     <= 1'b0;
      mem_we     <= 1'b0;
      mem_paddr  <= 24'h00_0000;
      mem_exc    <= 1'b0;
      fault_addr <= `PMMG_NO_FAULT;
    end else begin
      mem_en    <= mem_req && !violation;
      mem_we    <= mem_req && is_wr && !violation;
      mem_paddr <= paddr;
      mem_exc   <= violation;
      if (violation)
        fault_addr <= mem_vaddr;
    end
  end

  // --------------------------------------------------------------------------
  // Register gate; factory key lives in plain EEPROM and is never checked here
  // --------------------------------------------------------------------------
  // Register rights follow the segment code was last fetched from, not the data address
  logic [GROUPS-1:0] code_periph;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      code_periph <= '0;
    else if (mem_req && mem_kind == PMMG_ACC_FETCH && !violation)
      code_periph <= hit_periph;
  end
  wire [GROUPS-1:0] grp_rights = is_user ? code_periph : '1;
  wire              is_sfr     = reg_addr >= `PMMG_REG_SFR_BASE
                                 && reg_addr < 8'(`PMMG_REG_SFR_BASE + GROUPS);
  wire [3:0]        grp        = 4'(reg_addr - `PMMG_REG_SFR_BASE);
  wire              grp_ok     = grp_rights[grp];
  // Segment table writes allowed only in system, boot and test modes (fixed rule)
  wire              tbl_ok     = sys_cfg;

  // Segment table and peripheral register writes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seg_sel <= 6'h00;
      for (int i = 0; i < SEGS; i++) begin
        seg_rights[i] <= 4'h8;
        seg_start[i]  <= 24'h00_0000;
        seg_end[i]    <= 24'h00_0000;
        seg_offs[i]   <= 24'h00_0000;
        seg_periph[i] <= '0;
      end
      for (int g = 0; g < GROUPS; g++)
        sfr_bank[g] <= 32'h0000_0000;
    end else if (reg_wr) begin
      if (tbl_ok) begin
        unique case (reg_addr)
          `PMMG_REG_SEG_SEL:    seg_sel             <= reg_wdata[5:0];
          `PMMG_REG_SEG_RIGHTS: seg_rights[seg_sel] <= reg_wdata[3:0];
          `PMMG_REG_SEG_START:  seg_start[seg_sel]  <= reg_wdata[23:0];
          `PMMG_REG_SEG_END:    seg_end[seg_sel]    <= reg_wdata[23:0];
          `PMMG_REG_SEG_OFFS:   seg_offs[seg_sel]   <= reg_wdata[23:0];
          `PMMG_REG_SEG_PERIPH: seg_periph[seg_sel] <= reg_wdata[GROUPS-1:0];
          default: ;
        endcase
      end
      if (is_sfr && grp_ok)
        sfr_bank[grp] <= reg_wdata;
    end
  end

  // Read mux; refused reads give a fixed value
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    if (is_sfr)
      rd_val = grp_ok ? sfr_bank[grp] : `PMMG_SFR_DENY_VAL;
    else if (reg_addr == `PMMG_REG_PSW)
      rd_val = {30'h0, ssm_flag, sm_flag};
    else if (reg_addr == `PMMG_REG_CTRL)
      rd_val = {29'h0, delivered, mode != PMMG_BOOT, wp_lock};
    else if (reg_addr == `PMMG_REG_STATUS)
      rd_val = {27'h0, test_left, 1'b0, mode};
    else if (reg_addr == `PMMG_REG_FAULT_ADDR)
      rd_val = {8'h00, fault_addr};
    else if (tbl_ok) begin
      if (reg_addr == `PMMG_REG_SEG_SEL)    rd_val = {26'h0, seg_sel};
      if (reg_addr == `PMMG_REG_SEG_RIGHTS) rd_val = {28'h0, seg_rights[seg_sel]};
      if (reg_addr == `PMMG_REG_SEG_START)  rd_val = {8'h00, seg_start[seg_sel]};
      if (reg_addr == `PMMG_REG_SEG_END)    rd_val = {8'h00, seg_end[seg_sel]};
      if (reg_addr == `PMMG_REG_SEG_OFFS)   rd_val = {8'h00, seg_offs[seg_sel]};
      if (reg_addr == `PMMG_REG_SEG_PERIPH) rd_val = 32'(seg_periph[seg_sel]);
    end
  end

  // Read data registered one cycle after the strobe; zero otherwise
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0000_0000;
      cpu_mode  <= PMMG_BOOT;
    end else begin
      reg_rdata <= reg_rd ? rd_val : 32'h0000_0000;
      cpu_mode  <= next_mode;
    end
  end

endmodule : pmmg_guard
`default_nettype wire

// file: src/pmmg_map.svh
// Purpose: Offsets, field positions, reset values and sizes of the memory guard
// Assumes: Byte addressed 24-bit virtual and physical space
// Notes:   Definitions only
`ifndef PMMG_MAP_SVH
`define PMMG_MAP_SVH
// ----------------------------------------------------------------------------
// Register offsets (word index on the register port)
// ----------------------------------------------------------------------------
`define PMMG_REG_PSW        8'h00
`define PMMG_REG_CTRL       8'h01
`define PMMG_REG_STATUS     8'h02
`define PMMG_REG_SEG_SEL    8'h03
`define PMMG_REG_SEG_RIGHTS 8'h04
`define PMMG_REG_SEG_START  8'h05
`define PMMG_REG_SEG_END    8'h06
`define PMMG_REG_SEG_OFFS   8'h07
`define PMMG_REG_SEG_PERIPH 8'h08
`define PMMG_REG_FAULT_ADDR 8'h09
`define PMMG_REG_SFR_BASE   8'h40
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PMMG_PSW_SSM_BIT    1
`define PMMG_PSW_SM_BIT     0
`define PMMG_CTRL_WP_BIT    0
`define PMMG_CTRL_BOOTDONE  1
`define PMMG_CTRL_DELIVER   2
`define PMMG_RIGHT_R        0
`define PMMG_RIGHT_W        1
`define PMMG_RIGHT_X        2
`define PMMG_RIGHT_END      3
// ----------------------------------------------------------------------------
// Memory layout
// ----------------------------------------------------------------------------
`define PMMG_EE_BASE        24'h10_0000
`define PMMG_EE_SIZE        24'h01_0000
`define PMMG_EE_SPLIT       24'h00_8000
`define PMMG_ROM_BASE       24'h00_0000
`define PMMG_ROM_SIZE       24'h04_0000
`define PMMG_ROM_SPLIT      24'h02_0000
`define PMMG_RAM_BASE       24'h20_0000
`define PMMG_RAM_SIZE       24'h00_1000
`define PMMG_FUSE_BYTES     24'h00_0080
`define PMMG_RO_BYTES       24'h00_0020
`define PMMG_WP_BYTES       24'h00_0010
`define PMMG_WO_BYTES       24'h00_0020
`define PMMG_SFR_DENY_VAL   32'h0000_0000
`define PMMG_NO_FAULT       24'h00_0000
`endif

// file: src/pmmg_pkg.sv
// Purpose: Types of the memory guard
// Assumes: Constants live in pmmg_map.svh
// Notes:   Binary mode codes
package pmmg_pkg;
  typedef enum logic [2:0] {
    PMMG_BOOT   = 3'b000,
    PMMG_TEST   = 3'b001,
    PMMG_CLESS  = 3'b010,
    PMMG_SYSTEM = 3'b011,
    PMMG_USER   = 3'b100
  } pmmg_mode_e;
  typedef enum logic [1:0] {
    PMMG_ACC_READ  = 2'b00,
    PMMG_ACC_WRITE = 2'b01,
    PMMG_ACC_FETCH = 2'b10
  } pmmg_acc_e;
endpackage : pmmg_pkg

// file: testbench/pmmg_guard_props.sv
// Purpose: Port assertions for the privileged mode memory guard
// Assumes: Mode codes from pmmg_pkg, layout from pmmg_map.svh
// Notes:   Bound to pmmg_guard from the testbench top file
`timescale 1ns/1ps
`default_nettype none
`include "pmmg_map.svh"

module pmmg_guard_props
  import pmmg_pkg::*;
#(
  parameter int SEGS   = 64,
  parameter int GROUPS = 16
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // Mode events
  input wire logic        test_avail,
  input wire logic        svec_call,
  input wire logic        user_call,
  input wire logic        cless_req,
  input wire logic        test_req,
  // CPU access
  input wire logic        mem_req,
  input wire logic [1:0]  mem_kind,
  input wire logic [23:0] mem_vaddr,
  // Memory side
  input wire logic        mem_en,
  input wire logic        mem_we,
  input wire logic [23:0] mem_paddr,
  input wire logic        mem_exc,
  // Register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [2:0]  cpu_mode
);
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // A refused access must never reach the memory
  exc_blocks_a: assert property (mem_exc |-> !mem_en && !mem_we)
    else $error("exception raised with memory access enabled");
  grant_cause_a: assert property (mem_en |-> $past(mem_req))
    else $error("memory enable without a CPU request");
  write_kind_a: assert property (mem_we |-> mem_en && $past(mem_kind) == 2'b01)
    else $error("memory write without a write request");
  // Privileged modes bypass segments, so an address past RAM is always out of range
  range_exc_a: assert property (mem_req && cpu_mode != PMMG_USER &&
      mem_vaddr >= (`PMMG_RAM_BASE + `PMMG_RAM_SIZE) |=> mem_exc)
    else $error("out of range address not refused");
  boot_once_a: assert property (cpu_mode != PMMG_BOOT |=> cpu_mode != PMMG_BOOT)
    else $error("boot mode entered again");
  test_gate_a: assert property (cpu_mode != PMMG_TEST && cpu_mode != PMMG_BOOT
      |=> cpu_mode != PMMG_TEST)
    else $error("test mode entered from outside boot");
  cless_step_a: assert property (cless_req && cpu_mode == PMMG_TEST
      |-> ##[1:2] cpu_mode == PMMG_CLESS)
    else $error("contactless request ignored in test mode");
  svec_step_a: assert property (svec_call && cpu_mode == PMMG_USER
      |-> ##[1:2] cpu_mode == PMMG_SYSTEM)
    else $error("vector call did not enter system mode");
  flag_clear_a: assert property (cpu_mode == PMMG_SYSTEM && reg_wr &&
      reg_addr == `PMMG_REG_PSW && reg_wdata[1:0] == 2'b00 |-> ##[1:2] cpu_mode == PMMG_USER)
    else $error("clearing the flags did not enter user mode");

  // Main scenarios
  user_exit_c: cover property (cpu_mode == PMMG_USER ##1 cpu_mode == PMMG_SYSTEM);
  refused_c: cover property (mem_exc);
  cless_c: cover property (cpu_mode == PMMG_CLESS);
endmodule : pmmg_guard_props
`default_nettype wire

// file: testbench/pmmg_cpu_model.sv
// Purpose: CPU core model issuing virtual memory accesses to the guard
// Assumes: One request cycle, answer registered one cycle later
// Notes:   Address bus shows the inverse after release, never a stale value
`timescale 1ns/1ps
`default_nettype none

module pmmg_cpu_model (
  // Clock
  input  wire logic        clk,
  // Requests towards the guard
  output logic             mem_req,
  output logic [1:0]       mem_kind,
  output logic [23:0]      mem_vaddr,
  // Answers from the guard
  input  wire logic        mem_en,
  input  wire logic        mem_we,
  input  wire logic [23:0] mem_paddr,
  input  wire logic        mem_exc
);
  // Idle bus at time zero
  initial begin
    mem_req   = 1'b0;
    mem_kind  = 2'b00;
    mem_vaddr = 24'h00_0000;
  end

  // One access: request, release, then take the registered answer
  task automatic access(input logic [1:0] kind, input logic [23:0] va, output logic [31:0] res);
    @(posedge clk);
    mem_req   <= 1'b1;
    mem_kind  <= kind;
    mem_vaddr <= va;
    @(posedge clk);
    mem_req   <= 1'b0;
    mem_kind  <= ~kind;
    mem_vaddr <= ~va;
    @(posedge clk);
    res = {4'h0, mem_exc, mem_en, mem_we, 1'b0, mem_paddr};
  endtask : access
endmodule : pmmg_cpu_model
`default_nettype wire

// file: testbench/privileged_mode_memory_guard_test.sv
// Purpose: Self-checking bench for the memory guard
// Assumes: Lower halves of ROM and EEPROM are the accessible parts
// Notes:   Fuse row order read only, write protect, write once, hidden
`timescale 1ns/1ps
`default_nettype none
`include "pmmg_map.svh"

module privileged_mode_memory_guard_test
  import pmmg_pkg::*;
;
  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        test_avail = 1'b0;
  logic [3:0]  ev = 4'h0;
  logic        mem_req, mem_en, mem_we, mem_exc, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [1:0]  mem_kind;
  logic [23:0] mem_vaddr, mem_paddr;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata;
  logic [2:0]  cpu_mode;
  int          n_fail = 0;
  int          cmp_count = 0;

  always #20 clk = ~clk;

  pmmg_guard uut (.clk(clk), .rst_b(rst_b), .test_avail(test_avail), .svec_call(ev[0]),
    .user_call(ev[1]), .cless_req(ev[2]), .test_req(ev[3]), .mem_req(mem_req),
    .mem_kind(mem_kind), .mem_vaddr(mem_vaddr), .mem_en(mem_en), .mem_we(mem_we),
    .mem_paddr(mem_paddr), .mem_exc(mem_exc), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_mode(cpu_mode));
  pmmg_cpu_model cpu (.clk(clk), .mem_req(mem_req), .mem_kind(mem_kind),
    .mem_vaddr(mem_vaddr), .mem_en(mem_en), .mem_we(mem_we), .mem_paddr(mem_paddr),
    .mem_exc(mem_exc));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic rst(input logic ta);
    test_avail <= ta;
    rst_b      <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
  endtask : rst

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    chk(nm, exp, reg_rdata);
  endtask : rd

  task automatic pulse(input logic [3:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 4'h0;
  endtask : pulse

  // Two edges let a registered mode change land before the look
  task automatic mode(input pmmg_mode_e m);
    repeat (2) @(posedge clk);
    chk("cpu_mode", {29'h0, m}, {29'h0, cpu_mode});
  endtask : mode

  // Refused accesses still show the address on mem_paddr, so it is masked then
  task automatic mem(input string nm, input logic [1:0] k, input logic [23:0] va,
                     input logic ex, input logic [23:0] pa);
    logic [31:0] r;
    cpu.access(k, va, r);
    if (ex) r[23:0] = 24'h00_0000;
    chk(nm, {4'h0, ex, !ex, !ex && k == 2'b01, 1'b0, ex ? 24'h00_0000 : pa}, r);
  endtask : mem

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_boot;
    rst(1'b1);
    mode(PMMG_BOOT);
    wr(`PMMG_REG_CTRL, 32'h0000_0002);
    mode(PMMG_TEST);
    mem("test_upper", 2'b00, 24'h10_8000, 1'b0, 24'h10_8000);
    pulse(4'h4);
    mode(PMMG_CLESS);
    rd("status", `PMMG_REG_STATUS, 32'h0000_0012);
    pulse(4'h8);
    mode(PMMG_CLESS);
    $display("test t_boot done");
  endtask : t_boot

  task automatic t_deliver;
    rst(1'b1);
    wr(`PMMG_REG_CTRL, 32'h0000_0004);
    pulse(4'h8);
    mode(PMMG_BOOT);
    wr(`PMMG_REG_CTRL, 32'h0000_0002);
    mode(PMMG_SYSTEM);
    $display("test t_deliver done");
  endtask : t_deliver

  task automatic t_fuse;
    mem("rom_rd", 2'b00, 24'h00_0100, 1'b0, 24'h00_0100);
    mem("ee_upper", 2'b00, 24'h10_8000, 1'b1, 24'h00_0000);
    mem("no_mem", 2'b00, 24'h30_0000, 1'b1, 24'h00_0000);
    mem("ro_wr", 2'b01, 24'h10_7F80, 1'b1, 24'h00_0000);
    mem("ro_rd", 2'b00, 24'h10_7F80, 1'b0, 24'h10_7F80);
    mem("wp_open", 2'b01, 24'h10_7FA0, 1'b0, 24'h10_7FA0);
    wr(`PMMG_REG_CTRL, 32'h0000_0001);
    mem("wp_lock", 2'b01, 24'h10_7FA0, 1'b1, 24'h00_0000);
    mem("wo_wr", 2'b01, 24'h10_7FC0, 1'b0, 24'h10_7FC0);
    mem("hidden", 2'b00, 24'h10_7FE0, 1'b1, 24'h00_0000);
    mem("fab_key", 2'b01, 24'h10_0010, 1'b0, 24'h10_0010);
    $display("test t_fuse done");
  endtask : t_fuse

  task automatic t_user;
    rd("psw_sys", `PMMG_REG_PSW, 32'h0000_0001);
    wr(`PMMG_REG_SEG_SEL, 32'h0000_0000);
    wr(`PMMG_REG_SEG_RIGHTS, 32'h0000_0005);
    wr(`PMMG_REG_SEG_START, 32'h0000_0000);
    wr(`PMMG_REG_SEG_END, 32'h0000_0FFF);
    wr(`PMMG_REG_SEG_OFFS, 32'h0000_0100);
    wr(`PMMG_REG_SEG_PERIPH, 32'h0000_0001);
    wr(`PMMG_REG_SFR_BASE, 32'h0000_00AB);
    wr(`PMMG_REG_SFR_BASE + 8'h01, 32'h0000_0055);
    wr(`PMMG_REG_PSW, 32'h0000_0000);
    mode(PMMG_USER);
    wr(`PMMG_REG_PSW, 32'h0000_0003);
    rd("psw_user", `PMMG_REG_PSW, 32'h0000_0000);
    mem("seg_rd", 2'b00, 24'h00_0010, 1'b0, 24'h00_0110);
    mem("seg_fetch", 2'b10, 24'h00_0020, 1'b0, 24'h00_0120);
    rd("grp0_user", `PMMG_REG_SFR_BASE, 32'h0000_00AB);
    rd("grp1_user", `PMMG_REG_SFR_BASE + 8'h01, `PMMG_SFR_DENY_VAL);
    wr(`PMMG_REG_SFR_BASE + 8'h01, 32'h0000_0077);
    pulse(4'h1);
    mode(PMMG_SYSTEM);
    rd("grp1_sys", `PMMG_REG_SFR_BASE + 8'h01, 32'h0000_0055);
    pulse(4'h2);
    mode(PMMG_USER);
    mem("seg_wr", 2'b01, 24'h00_0010, 1'b1, 24'h00_0000);
    mode(PMMG_SYSTEM);
    rd("fault", `PMMG_REG_FAULT_ADDR, 32'h0000_0010);
    $display("test t_user done");
  endtask : t_user

  // ---------------------------------------------------------------
  // Run control
  // ---------------------------------------------------------------
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run

  // Whole run needs about 130 cycles
  initial begin
    #(40 * 3000);
    n_fail++;
    complete_run();
  end

  initial begin
    t_boot();
    t_deliver();
    t_fuse();
    t_user();
    complete_run();
  end
endmodule : privileged_mode_memory_guard_test

bind pmmg_guard pmmg_guard_props #(.SEGS(SEGS), .GROUPS(GROUPS)) u_props (
  .clk(clk), .rst_b(rst_b), .test_avail(test_avail), .svec_call(svec_call),
  .user_call(user_call), .cless_req(cless_req), .test_req(test_req), .mem_req(mem_req),
  .mem_kind(mem_kind), .mem_vaddr(mem_vaddr), .mem_en(mem_en), .mem_we(mem_we),
  .mem_paddr(mem_paddr), .mem_exc(mem_exc), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_mode(cpu_mode));
`default_nettype wire
